// >>> hdl/dma_pkg.sv
// shared constants and types for the descriptor list dma engine
package dma_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [7:0] OP_MODE_OFS   = 8'h00;
	localparam logic [7:0] TX_POLL_OFS   = 8'h04;
	localparam logic [7:0] RX_POLL_OFS   = 8'h08;
	localparam logic [7:0] RX_BASE_OFS   = 8'h0c;
	localparam logic [7:0] TX_BASE_OFS   = 8'h10;
	localparam logic [7:0] IRQ_STAT_OFS  = 8'h14;
	localparam logic [7:0] PROC_STAT_OFS = 8'h18;
	// op mode and irq status bit positions
	localparam int OP_RX_START = 0;
	localparam int OP_TX_START = 1;
	localparam int IRQ_TX_DONE = 0;
	localparam int IRQ_JABBER  = 3;
	localparam int IRQ_W       = 4;
	// descriptor geometry
	localparam logic [31:0] DESC_STEP = 32'h0000_0010;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	// control word fields
	localparam int OWN_BIT       = 31;
	localparam int CTL_IRQ       = 31;
	localparam int CTL_LAST      = 30;
	localparam int CTL_FIRST     = 29;
	localparam int CTL_FM_HIGH   = 28;
	localparam int CTL_SETUP     = 27;
	localparam int CTL_CRC_OFF   = 26;
	localparam int CTL_RING_END  = 25;
	localparam int CTL_CHAIN     = 24;
	localparam int CTL_PAD_OFF   = 23;
	localparam int CTL_FM_LOW    = 22;
	localparam int CTL_LEN2_LSB  = 11;
	localparam int CTL_LEN1_LSB  = 0;
	localparam int LEN_W         = 11;
	localparam int WCNT_W        = 10;
	// receive status word fields
	localparam int RX_FIRST_BIT  = 9;
	localparam int RX_LAST_BIT   = 8;
	localparam int RX_LEN_W      = 14;
	// transmit status word fields
	localparam int ST_ERR_SUM    = 15;
	localparam int ST_JABBER     = 14;
	localparam int ST_CARR_LOST  = 11;
	localparam int ST_NO_CARR    = 10;
	localparam int ST_LATE_COLL  = 9;
	localparam int ST_EXCESS     = 8;
	localparam int ST_HEARTBEAT  = 7;
	localparam int ST_COLL_LSB   = 3;
	localparam int ST_LINK_FAIL  = 2;
	localparam int ST_UNDERRUN   = 1;
	localparam int ST_DEFERRED   = 0;

	typedef enum logic [1:0] {STOPPED = 2'b00, RUNNING = 2'b01, SUSPENDED = 2'b11} proc_state_t;
	typedef enum logic [1:0] {E_IDLE = 2'b00, E_FETCH = 2'b01, E_MOVE = 2'b11, E_WRITE = 2'b10} engine_state_t;

	// one classic wishbone master request toward host memory
	typedef struct packed {
		logic        cyc;
		logic        we;
		logic [31:0] adr;
		logic [31:0] dat;
	} mem_req_t;

	// per frame result reported by the mac after sending
	typedef struct packed {
		logic       jabber_truncated;
		logic       carrier_lost;
		logic       no_carrier;
		logic       late_collision;
		logic       excess_collisions;
		logic       heartbeat_fail;
		logic [3:0] collision_count;
		logic       link_test_fail;
		logic       fifo_underrun;
		logic       deferred_flag;
		logic       internal_loopback;
	} tx_stat_t;

	// per frame options handed to the mac
	typedef struct packed {
		logic       crc_append_off;
		logic       pad_off;
		logic       setup_frame_flag;
		logic [1:0] filter_mode;
	} tx_ctrl_t;
endpackage

// >>> hdl/descriptor_list_dma.sv
// descriptor list dma engine with wishbone register slave
// What this block does
// R01 - ring end flag returns to list base
// R02 - chain flag makes word3 next descriptor
// R03 - lengths in 21-11 and 10-0, chain ignores second
// R04 - four word descriptors, buffer addresses in words 2,3
// R05 - device clears transmit ownership after sending buffer
// R06 - transmit status written, bit 15 error summary
// R07 - jabber truncation sets bit 14 and irq bit 3
// R08 - carrier lost bit 11, no carrier bit 10
// R09 - late collision bit 9, invalid under underrun
// R10 - sixteen collisions abort, excess flag bit 8
// R11 - heartbeat bit 7, collision count bits 6-3
// R12 - link fail bit 2, underrun 1, deferred 0
// R13 - completion irq only on last or setup
// R14 - frames assembled from first and last markers
// R15 - setup frame flag and filter mode bits
// R16 - crc append off honoured on first segment
// R17 - pad off suppresses short frame padding
// R18 - reset stops both, start bit runs them
// R19 - receiver prefetches descriptors on five events
// R20 - receive status to last descriptor, suspend on host-owned
// R21 - transmit suspends on host-owned or local error
// R22 - transmitter copies second frame before first status
// R23 - lists start at their base registers
// R24 - receive ownership cleared when reception completes
// R25 - zero length buffers skipped without transfer
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module descriptor_list_dma (
	input  wire logic              clk,           // 10 mhz system clock
	input  wire logic              rst_n,         // async reset, active low
	input  wire logic              wb_cyc_i,      // slave cycle
	input  wire logic              wb_stb_i,      // slave strobe
	input  wire logic              wb_we_i,       // slave write enable
	input  wire logic [7:0]        wb_adr_i,      // slave byte address
	input  wire logic [3:0]        wb_sel_i,      // slave byte lanes
	input  wire logic [31:0]       wb_dat_i,      // slave write data
	output logic [31:0]            wb_dat_o,      // slave read data
	output logic                   wb_ack_o,      // slave acknowledge
	output dma_pkg::mem_req_t      mem_req,       // master request to host memory
	input  wire logic [31:0]       mem_rdata,     // master read data
	input  wire logic              mem_ack,       // master acknowledge
	input  wire logic              rx_valid,      // receive word offered
	input  wire logic [31:0]       rx_data,       // receive word
	input  wire logic              rx_last,       // word ends the frame
	input  wire logic [15:0]       rx_status,     // frame status with last word
	input  wire logic [13:0]       rx_len,        // frame byte count with last word
	output logic                   rx_ready,      // receive word taken
	output logic                   tx_valid,      // transmit word offered
	output logic [31:0]            tx_data,       // transmit word
	output logic                   tx_last,       // word ends the frame
	input  wire logic              tx_ready,      // mac takes transmit word
	output dma_pkg::tx_ctrl_t      tx_ctrl,       // frame options of current frame
	input  wire logic              tx_stat_valid, // frame result pulse
	input  wire dma_pkg::tx_stat_t tx_stat,       // frame result
	output logic                   tx_done        // completion pulse
);
	dma_pkg::engine_state_t     eng;
	dma_pkg::proc_state_t       rx_st, tx_st;
	logic                       on_rx, wstat;
	logic [1:0]                 widx;
	logic [1:0]                 op_mode;
	logic [31:0]                rx_base, tx_base;
	logic [dma_pkg::IRQ_W-1:0]  irq_stat;
	logic                       rx_poll, tx_poll;
	logic [31:0]                rx_cur, rx_ctl, rx_b1, rx_w3, rx_ptr, rx_fin;
	logic [31:0]                tx_cur, tx_ctl, tx_b1, tx_w3, tx_ptr, tx_sw;
	logic                       rx_have, rx_buf, rx_first, rx_end;
	logic                       tx_have, tx_buf, tx_sv, tx_sloc;
	logic [dma_pkg::WCNT_W-1:0] rx_left, tx_left;
	logic [1:0][31:0]           tx_pa;
	logic [1:0]                 tx_pirq;
	logic [1:0]                 tx_np;
	logic [31:0]                rx_end_word, rx_close_word, cur, wb_mask;
	logic [dma_pkg::LEN_W-1:0]  rx_len2, tx_len2;
	logic                       busy, ack, stat_wr, wb_hit, wb_wr;

	// words needed for a byte length, rounded up
	function automatic logic [dma_pkg::WCNT_W-1:0] buf_words(input logic [dma_pkg::LEN_W-1:0] len);
		logic [dma_pkg::LEN_W:0] t;
		t = {1'b0, len} + {{(dma_pkg::LEN_W-1){1'b0}}, 2'b11};
		return t[dma_pkg::LEN_W:2];
	endfunction

	// address of the descriptor that follows the current one
	function automatic logic [31:0] next_desc(input logic [31:0] c, input logic [31:0] ctl,
		input logic [31:0] w3, input logic [31:0] base);
		logic [31:0] n;
		n = c + dma_pkg::DESC_STEP;
		if (ctl[dma_pkg::CTL_CHAIN]) n = w3;        // see R02
		if (ctl[dma_pkg::CTL_RING_END]) n = base;   // see R01
		return n;
	endfunction

	// transmit status word with the invalid combinations masked off
	function automatic logic [31:0] tx_status_word(input dma_pkg::tx_stat_t s);
		logic [31:0] w;
		w = '0;
		w[dma_pkg::ST_JABBER]    = s.jabber_truncated;                            // see R07
		w[dma_pkg::ST_CARR_LOST] = s.carrier_lost & ~s.internal_loopback;         // see R08
		w[dma_pkg::ST_NO_CARR]   = s.no_carrier & ~s.internal_loopback;           // see R08
		w[dma_pkg::ST_LATE_COLL] = s.late_collision & ~s.fifo_underrun;           // see R09
		w[dma_pkg::ST_EXCESS]    = s.excess_collisions;                           // see R10
		w[dma_pkg::ST_HEARTBEAT] = s.heartbeat_fail & ~s.fifo_underrun & ~s.jabber_truncated; // see R11
		w[dma_pkg::ST_COLL_LSB +: 4] = s.excess_collisions ? 4'h0 : s.collision_count; // see R11
		w[dma_pkg::ST_LINK_FAIL] = s.link_test_fail;                              // see R12
		w[dma_pkg::ST_UNDERRUN]  = s.fifo_underrun;                               // see R12
		w[dma_pkg::ST_DEFERRED]  = s.deferred_flag;                               // see R12
		w[dma_pkg::ST_ERR_SUM]   = w[dma_pkg::ST_JABBER] | w[dma_pkg::ST_CARR_LOST] | w[dma_pkg::ST_NO_CARR]
			| w[dma_pkg::ST_LATE_COLL] | w[dma_pkg::ST_EXCESS] | w[dma_pkg::ST_UNDERRUN]; // see R06
		return w;
	endfunction

	// handshake terms and the second buffer length, dropped in chain form
	assign busy    = mem_req.cyc;
	assign ack     = mem_req.cyc & mem_ack;
	assign stat_wr = (eng == dma_pkg::E_WRITE) & wstat & ack;
	assign wb_hit  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr   = wb_hit & wb_we_i;
	assign wb_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign rx_len2 = rx_ctl[dma_pkg::CTL_CHAIN] ? '0 : rx_ctl[dma_pkg::CTL_LEN2_LSB +: dma_pkg::LEN_W]; // see R03
	assign tx_len2 = tx_ctl[dma_pkg::CTL_CHAIN] ? '0 : tx_ctl[dma_pkg::CTL_LEN2_LSB +: dma_pkg::LEN_W]; // see R03
	assign cur     = on_rx ? rx_cur : tx_cur;

	// receive word0 images: closing a full buffer, and ending a frame
	always_comb begin
		rx_end_word = rx_fin;
		rx_end_word[dma_pkg::OWN_BIT] = 1'b0;        // see R24
		rx_end_word[dma_pkg::RX_FIRST_BIT] = rx_first;
		rx_end_word[dma_pkg::RX_LAST_BIT] = 1'b1;
		rx_close_word = '0;
		rx_close_word[dma_pkg::RX_FIRST_BIT] = rx_first;
	end

	// wishbone slave: one wait state, unmapped reads give zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			op_mode  <= '0;
			rx_base  <= '0;
			tx_base  <= '0;
			rx_poll  <= 1'b0;
			tx_poll  <= 1'b0;
		end else begin
			wb_ack_o <= wb_hit;
			rx_poll  <= wb_wr & (wb_adr_i == dma_pkg::RX_POLL_OFS);
			tx_poll  <= wb_wr & (wb_adr_i == dma_pkg::TX_POLL_OFS);
			if (wb_wr && wb_adr_i == dma_pkg::OP_MODE_OFS && wb_sel_i[0]) begin
				op_mode <= wb_dat_i[1:0];
			end
			if (wb_wr && wb_adr_i == dma_pkg::RX_BASE_OFS) begin
				rx_base <= (rx_base & ~wb_mask) | (wb_dat_i & wb_mask);
			end
			if (wb_wr && wb_adr_i == dma_pkg::TX_BASE_OFS) begin
				tx_base <= (tx_base & ~wb_mask) | (wb_dat_i & wb_mask);
			end
			if (wb_hit && !wb_we_i) begin
				unique case (wb_adr_i)
					dma_pkg::OP_MODE_OFS:   wb_dat_o <= {30'h0, op_mode};
					dma_pkg::RX_BASE_OFS:   wb_dat_o <= rx_base;
					dma_pkg::TX_BASE_OFS:   wb_dat_o <= tx_base;
					dma_pkg::IRQ_STAT_OFS:  wb_dat_o <= {28'h0, irq_stat};
					dma_pkg::PROC_STAT_OFS: wb_dat_o <= {26'h0, tx_np, tx_st, rx_st};
					default:                wb_dat_o <= '0;
				endcase
			end else begin
				wb_dat_o <= '0;
			end
		end
	end

	// sticky status: write one clears, a new event in the same cycle wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~((wb_wr && wb_adr_i == dma_pkg::IRQ_STAT_OFS && wb_sel_i[0])
				? wb_dat_i[dma_pkg::IRQ_W-1:0] : '0))
				| {stat_wr & tx_sw[dma_pkg::ST_JABBER], 2'b00, stat_wr & tx_pirq[0]}; // see R07
		end
	end

	// descriptor engine: fetch, data move and write back for both lists
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eng <= dma_pkg::E_IDLE;
			rx_st <= dma_pkg::STOPPED;                  // see R18
			tx_st <= dma_pkg::STOPPED;
			mem_req <= '0;
			{on_rx, wstat, widx} <= '0;
			{rx_cur, rx_ctl, rx_b1, rx_w3, rx_ptr, rx_fin} <= '0;
			{tx_cur, tx_ctl, tx_b1, tx_w3, tx_ptr, tx_sw} <= '0;
			{rx_have, rx_buf, rx_end, rx_ready} <= '0;
			rx_first <= 1'b1;
			{tx_have, tx_buf, tx_sv, tx_sloc} <= '0;
			{rx_left, tx_left, tx_pa, tx_pirq, tx_np} <= '0;
			{tx_valid, tx_data, tx_last, tx_ctrl, tx_done} <= '0;
		end else begin
			tx_done <= 1'b0;
			if (ack) begin
				mem_req.cyc <= 1'b0;
			end
			if (tx_valid && tx_ready) begin
				tx_valid <= 1'b0;
			end
			unique case (eng)
				dma_pkg::E_IDLE: begin
					widx <= 2'h0;
					if (tx_sv && tx_np != 2'h0) begin
						mem_req <= '{cyc: 1'b1, we: 1'b1, adr: tx_pa[0], dat: tx_sw}; // see R06
						wstat <= 1'b1;
						on_rx <= 1'b0;
						eng <= dma_pkg::E_WRITE;
					end else if (rx_st == dma_pkg::RUNNING && !rx_have) begin   // see R19
						on_rx <= 1'b1;
						eng <= dma_pkg::E_FETCH;
					end else if (rx_have && rx_st != dma_pkg::STOPPED && (rx_valid || rx_end)) begin
						on_rx <= 1'b1;
						eng <= dma_pkg::E_MOVE;
					end else if (tx_st == dma_pkg::RUNNING && !tx_have && tx_np != 2'h2) begin // see R22
						on_rx <= 1'b0;
						eng <= dma_pkg::E_FETCH;
					end else if (tx_have && tx_st != dma_pkg::STOPPED) begin
						on_rx <= 1'b0;
						eng <= dma_pkg::E_MOVE;
					end
				end
				dma_pkg::E_FETCH: begin
					if (ack) begin
						widx <= widx + 2'h1;
						if (widx == 2'h0 && !mem_rdata[dma_pkg::OWN_BIT]) begin
							if (on_rx) rx_st <= dma_pkg::SUSPENDED;            // see R20
							else tx_st <= dma_pkg::SUSPENDED;                   // see R21
							eng <= dma_pkg::E_IDLE;
						end else if (widx == 2'h1) begin
							if (on_rx) rx_ctl <= mem_rdata;
							else tx_ctl <= mem_rdata;
						end else if (widx == 2'h2) begin
							if (on_rx) rx_b1 <= mem_rdata;                      // see R04
							else tx_b1 <= mem_rdata;
						end else if (widx == 2'h3) begin
							eng <= dma_pkg::E_IDLE;
							if (on_rx) begin
								rx_w3 <= mem_rdata;
								rx_have <= 1'b1;
								rx_buf <= 1'b0;
								rx_ptr <= rx_b1;
								rx_left <= buf_words(rx_ctl[dma_pkg::CTL_LEN1_LSB +: dma_pkg::LEN_W]); // see R03
							end else begin
								tx_w3 <= mem_rdata;
								tx_have <= 1'b1;
								tx_buf <= 1'b0;
								tx_ptr <= tx_b1;
								tx_left <= buf_words(tx_ctl[dma_pkg::CTL_LEN1_LSB +: dma_pkg::LEN_W]);
								if (tx_ctl[dma_pkg::CTL_FIRST]) begin            // see R14
									tx_ctrl.crc_append_off <= tx_ctl[dma_pkg::CTL_CRC_OFF]; // see R16
									tx_ctrl.pad_off <= tx_ctl[dma_pkg::CTL_PAD_OFF];        // see R17
									tx_ctrl.setup_frame_flag <= tx_ctl[dma_pkg::CTL_SETUP]; // see R15
									tx_ctrl.filter_mode <= {tx_ctl[dma_pkg::CTL_FM_HIGH],
										tx_ctl[dma_pkg::CTL_FM_LOW]};                       // see R15
								end
							end
						end
					end else if (!busy) begin
						mem_req <= '{cyc: 1'b1, we: 1'b0, adr: cur + {28'h0, widx, 2'b00}, dat: '0}; // see R04
					end
				end
				dma_pkg::E_MOVE: begin
					if (on_rx) begin
						if (!busy) begin
							if (rx_end) begin
								mem_req <= '{cyc: 1'b1, we: 1'b1, adr: rx_cur, dat: rx_end_word}; // see R20
								rx_end <= 1'b0;
								rx_first <= 1'b1;
								wstat <= 1'b0;
								eng <= dma_pkg::E_WRITE;
							end else if (rx_left == '0) begin
								if (!rx_buf && rx_len2 != '0) begin                 // see R25
									rx_buf <= 1'b1;
									rx_ptr <= rx_w3;
									rx_left <= buf_words(rx_len2);
								end else begin
									mem_req <= '{cyc: 1'b1, we: 1'b1, adr: rx_cur, dat: rx_close_word}; // see R19
									rx_first <= 1'b0;
									rx_ready <= 1'b0;
									wstat <= 1'b0;
									eng <= dma_pkg::E_WRITE;
								end
							end else if (rx_ready && rx_valid) begin
								mem_req <= '{cyc: 1'b1, we: 1'b1, adr: rx_ptr, dat: rx_data};
								rx_ptr <= rx_ptr + dma_pkg::WORD_STEP;
								rx_left <= rx_left - {{(dma_pkg::WCNT_W-1){1'b0}}, 1'b1};
								rx_ready <= 1'b0;
								if (rx_last) begin
									rx_end <= 1'b1;
									rx_fin <= {2'b00, rx_len, rx_status};
								end
							end else if (rx_valid) begin
								rx_ready <= 1'b1;
							end else begin
								rx_ready <= 1'b0;
								eng <= dma_pkg::E_IDLE;
							end
						end
					end else begin
						if (ack) begin
							tx_data <= mem_rdata;
							tx_valid <= 1'b1;
						end else if (!busy && !tx_valid) begin
							if (tx_left == '0) begin
								if (!tx_buf && tx_len2 != '0) begin                 // see R25
									tx_buf <= 1'b1;
									tx_ptr <= tx_w3;
									tx_left <= buf_words(tx_len2);
								end else if (tx_ctl[dma_pkg::CTL_LAST]) begin       // see R22
									tx_pa[tx_np[0]] <= tx_cur;
									tx_pirq[tx_np[0]] <= tx_ctl[dma_pkg::CTL_IRQ]
										& (tx_ctl[dma_pkg::CTL_LAST] | tx_ctl[dma_pkg::CTL_SETUP]); // see R13
									tx_np <= tx_np + 2'h1;
									tx_have <= 1'b0;
									tx_cur <= next_desc(tx_cur, tx_ctl, tx_w3, tx_base);
									eng <= dma_pkg::E_IDLE;
								end else begin
									mem_req <= '{cyc: 1'b1, we: 1'b1, adr: tx_cur, dat: '0}; // see R05
									wstat <= 1'b0;
									eng <= dma_pkg::E_WRITE;
								end
							end else begin
								mem_req <= '{cyc: 1'b1, we: 1'b0, adr: tx_ptr, dat: '0};
								tx_ptr <= tx_ptr + dma_pkg::WORD_STEP;
								tx_left <= tx_left - {{(dma_pkg::WCNT_W-1){1'b0}}, 1'b1};
								tx_last <= tx_ctl[dma_pkg::CTL_LAST] && tx_left == {{(dma_pkg::WCNT_W-1){1'b0}}, 1'b1}
									&& (tx_buf || tx_len2 == '0);                       // see R14
							end
						end
					end
				end
				dma_pkg::E_WRITE: begin
					if (ack) begin
						eng <= dma_pkg::E_IDLE;
						if (wstat) begin
							tx_pa[0] <= tx_pa[1];
							tx_pirq[0] <= tx_pirq[1];
							tx_np <= tx_np - 2'h1;
							tx_sv <= 1'b0;
							tx_done <= tx_pirq[0];                                  // see R13
							if (tx_sloc && tx_st == dma_pkg::RUNNING) begin
								tx_st <= dma_pkg::SUSPENDED;                        // see R21
							end
						end else if (on_rx) begin
							rx_have <= 1'b0;
							rx_cur <= next_desc(rx_cur, rx_ctl, rx_w3, rx_base);
						end else begin
							tx_have <= 1'b0;
							tx_cur <= next_desc(tx_cur, tx_ctl, tx_w3, tx_base);
						end
					end
				end
			endcase
			// frame result from the mac; a new one wins over the write back clear
			if (tx_stat_valid) begin
				tx_sv <= 1'b1;
				tx_sw <= tx_status_word(tx_stat);
				tx_sloc <= tx_stat.fifo_underrun | tx_stat.jabber_truncated | tx_stat.excess_collisions; // see R10
			end
			// start, stop and resume of the receive process
			if (!op_mode[dma_pkg::OP_RX_START]) begin
				rx_st <= dma_pkg::STOPPED;
			end else if (rx_st == dma_pkg::STOPPED) begin
				rx_st <= dma_pkg::RUNNING;                                          // see R18
				rx_cur <= rx_base;                                                  // see R23
				rx_have <= 1'b0;
				rx_first <= 1'b1;
			end else if (rx_st == dma_pkg::SUSPENDED && (rx_poll || rx_valid)) begin
				rx_st <= dma_pkg::RUNNING;                                          // see R19
			end
			// start, stop and resume of the transmit process
			if (!op_mode[dma_pkg::OP_TX_START]) begin
				tx_st <= dma_pkg::STOPPED;
			end else if (tx_st == dma_pkg::STOPPED) begin
				tx_st <= dma_pkg::RUNNING;                                          // see R18
				tx_cur <= tx_base;                                                  // see R23
				tx_have <= 1'b0;
			end else if (tx_st == dma_pkg::SUSPENDED && tx_poll) begin
				tx_st <= dma_pkg::RUNNING;                                          // see R21
			end
		end
	end
endmodule

// >>> tb/dma_checker.sv
// concurrent checks on the dma engine ports
`timescale 1ns/1ps
module dma_checker (
	input wire logic              clk,      // system clock
	input wire logic              rst_n,    // reset, active low
	input wire logic              wb_cyc_i, // slave cycle
	input wire logic              wb_stb_i, // slave strobe
	input wire logic [31:0]       wb_dat_o, // read data
	input wire logic              wb_ack_o, // acknowledge
	input wire dma_pkg::mem_req_t mem_req,  // memory request
	input wire logic              mem_ack,  // memory acknowledge
	input wire logic              rx_valid, // receive offer
	input wire logic              rx_ready, // receive take
	input wire logic              tx_valid, // transmit offer
	input wire logic [31:0]       tx_data,  // transmit word
	input wire logic              tx_last,  // transmit end
	input wire logic              tx_ready, // transmit take
	input wire logic              tx_done   // completion pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// a memory cycle waiting for its answer keeps its request steady
	sequence s_mem_wait;
		mem_req.cyc && !mem_ack;
	endsequence
	sequence s_mem_held;
		mem_req.cyc && $stable(mem_req.adr) && $stable(mem_req.we) && $stable(mem_req.dat);
	endsequence
	a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("register ack missing");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("register ack too long");
	a_rdata_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_mem_held: assert property (s_mem_wait |=> s_mem_held)
		else $error("memory request changed");
	a_mem_release: assert property (mem_req.cyc && mem_ack |=> !mem_req.cyc)
		else $error("memory cycle not released");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("transmit word dropped");
	a_rx_take: assert property (rx_valid && rx_ready |=> !rx_ready)
		else $error("receive ready held");
	a_done_pulse: assert property (tx_done |=> !tx_done)
		else $error("completion pulse too long");
endmodule

// >>> tb/host_mem.sv
// host memory model answering the dma master port
`timescale 1ns/1ps
module host_mem (
	input  wire logic              clk,   // system clock
	input  wire logic              rst_n, // reset, active low
	input  wire dma_pkg::mem_req_t req,   // request from the engine
	output logic [31:0]            rdata, // read data
	output logic                   ack    // acknowledge
);
	logic [31:0] mem [0:255]; // words at address bits 9:2
	logic [1:0]  lat;         // cycles still to wait
	logic [1:0]  nxt;         // wait of the next access
	// answer after a varying wait; data lines toggle when idle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			rdata <= 32'h0;
			lat <= 2'h0;
			nxt <= 2'h1;
		end else if (req.cyc && !ack && lat == 2'h0) begin
			ack <= 1'b1;
			rdata <= mem[req.adr[9:2]];
			if (req.we) mem[req.adr[9:2]] <= req.dat;
			lat <= nxt;
			nxt <= nxt + 2'h1;
		end else begin
			ack <= 1'b0;
			rdata <= ~rdata;
			if (req.cyc && !ack) lat <= lat - 2'h1;
		end
	end
endmodule

// >>> tb/tb.sv
// self-checking bench for the descriptor list dma engine
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("BAD %0t %h vs %h", $time, a, b); end end
module tb;
	logic              clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mem_ack, sent;
	logic              rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, tx_stat_valid, tx_done;
	logic [7:0]        wb_adr_i;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i, wb_dat_o, mem_rdata, rx_data, tx_data, rd, exp, txq[$], rxq[$];
	logic [31:0]       seed = 32'h696b;
	logic [15:0]       rx_status;
	logic [13:0]       rx_len;
	dma_pkg::mem_req_t mem_req;
	dma_pkg::tx_ctrl_t tx_ctrl;
	dma_pkg::tx_stat_t tx_stat;
	int                errors = 0, check_count = 0, done_n = 0, n, i;
	descriptor_list_dma dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_last(rx_last), .rx_status(rx_status), .rx_len(rx_len), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .tx_ctrl(tx_ctrl),
		.tx_stat_valid(tx_stat_valid), .tx_stat(tx_stat), .tx_done(tx_done));
	host_mem mem_i (.clk(clk), .rst_n(rst_n), .req(mem_req), .rdata(mem_rdata), .ack(mem_ack));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic conclude();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic bound(input int k);
		if (k >= 100) begin
			errors++;
			conclude();
		end
	endtask
	// one classic wishbone cycle, waits for ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_sel_i <= 4'hf;
		wb_adr_i <= a;
		wb_dat_i <= d;
		k = 0;
		do begin @(posedge clk); k++; end while (wb_ack_o !== 1'b1 && k < 100);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		bound(k);
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// stalling mac sink compared with the expected word queue
	always @(posedge clk) begin
		tx_ready <= ^xs();
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			exp = txq.pop_front();
			`CHK(tx_data, exp)
			`CHK(tx_last, txq.size() == 0)
			sent = tx_last;
		end
		if (tx_done === 1'b1) done_n++;
	end
	initial begin
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, rx_valid, rx_last, tx_ready, tx_stat_valid, sent} = 9'h0;
		{wb_adr_i, wb_sel_i, wb_dat_i, rx_data, rx_len, rx_status} = {8'h0, 4'hf, 64'h0, 14'h8, 16'h0002};
		tx_stat = '0;
		for (i = 0; i < 256; i++) mem_i.mem[i] = 32'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		wb(0, dma_pkg::OP_MODE_OFS, 0, rd);
		`CHK(rd, 32'h0)
		wb(0, dma_pkg::PROC_STAT_OFS, 0, rd);
		`CHK(rd, 32'h0)
		wb(0, 8'hfc, 0, rd);
		`CHK(rd, 32'h0)
		// ring-end receive descriptor; a device-owned one after it must not be used
		mem_i.mem[8'h40] = 32'h8000_0000;
		mem_i.mem[8'h41] = 32'h0200_2004;
		mem_i.mem[8'h42] = 32'h0000_0180;
		mem_i.mem[8'h43] = 32'h0000_01c0;
		mem_i.mem[8'h44] = 32'h8000_0000;
		mem_i.mem[8'h45] = 32'h0000_0008;
		wb(1, dma_pkg::RX_BASE_OFS, 32'h100, rd);
		wb(1, dma_pkg::OP_MODE_OFS, 32'h1, rd);
		@(posedge clk);
		rx_valid <= 1'b1;
		for (i = 0; i < 2; i++) begin
			rxq.push_back(xs());
			rx_data <= rxq[i];
			rx_last <= (i == 1);
			n = 0;
			do begin @(posedge clk); n++; end while (rx_ready !== 1'b1 && n < 100);
			bound(n);
		end
		rx_valid <= 1'b0;
		n = 0;
		do begin wb(0, dma_pkg::PROC_STAT_OFS, 0, rd); n++; end while (rd[1:0] !== 2'b11 && n < 100);
		bound(n);
		`CHK(mem_i.mem[8'h60], rxq[0])
		`CHK(mem_i.mem[8'h70], rxq[1])
		`CHK(mem_i.mem[8'h40], 32'h0008_0302)
		// chained transmit descriptor; its successor is host owned, the ring neighbour is not
		mem_i.mem[8'h80] = 32'h8000_0000;
		mem_i.mem[8'h81] = 32'hfd80_0008;
		mem_i.mem[8'h82] = 32'h0000_0280;
		mem_i.mem[8'h83] = 32'h0000_0300;
		mem_i.mem[8'h84] = 32'h8000_0000;
		mem_i.mem[8'h85] = 32'h6000_0008;
		for (i = 0; i < 2; i++) begin
			mem_i.mem[8'ha0 + i] = xs();
			txq.push_back(mem_i.mem[8'ha0 + i]);
		end
		wb(1, dma_pkg::TX_BASE_OFS, 32'h200, rd);
		wb(1, dma_pkg::OP_MODE_OFS, 32'h3, rd);
		n = 0;
		do begin @(posedge clk); n++; end while (sent !== 1'b1 && n < 100);
		bound(n);
		`CHK(tx_ctrl, 5'h1e)
		tx_stat_valid <= 1'b1;
		tx_stat <= dma_pkg::tx_stat_t'(14'h355a);
		@(posedge clk);
		tx_stat_valid <= 1'b0;
		n = 0;
		do begin wb(0, dma_pkg::PROC_STAT_OFS, 0, rd); n++; end while (rd[5:2] !== 4'b0011 && n < 100);
		bound(n);
		`CHK(rd, 32'h0000_000f)
		`CHK(mem_i.mem[8'h80], 32'h0000_ca2d)
		`CHK(done_n, 1)
		wb(0, dma_pkg::IRQ_STAT_OFS, 0, rd);
		`CHK(rd, 32'h0000_0009)
		wb(1, dma_pkg::IRQ_STAT_OFS, 32'h9, rd);
		wb(0, dma_pkg::IRQ_STAT_OFS, 0, rd);
		`CHK(rd, 32'h0)
		conclude();
	end
endmodule
bind descriptor_list_dma dma_checker chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req(mem_req), .mem_ack(mem_ack), .rx_valid(rx_valid),
	.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
	.tx_done(tx_done));
